// file: src/rver_consts.vh
// Purpose: Constants for the regulator voltage and enable register bank
// Assumes: 8-bit registers reached through a simple byte register port
// Notes:   Offsets are register addresses on the serial register port
`ifndef RVER_CONSTS_VH
`define RVER_CONSTS_VH
`define RVER_ADDR_BUCK_ONE_VSEL   8'h01
`define RVER_ADDR_BUCK_TWO_LIN    8'h02
`define RVER_ADDR_ENABLE_STATUS   8'h03
`define RVER_BIT_BUCK_ONE_ON      7
`define RVER_BIT_BUCK_TWO_ON      6
`define RVER_BIT_LINEAR_ON        5
`define RVER_BIT_ENABLE_ALL       4
`define RVER_BIT_BUCK_ONE_OK      3
`define RVER_BIT_BUCK_TWO_OK      2
`define RVER_BIT_LINEAR_OK        1
`define RVER_BIT_RELEASE_FOLLOW   0
`define RVER_BUCK_ONE_CODE_MASK   8'h07
`define RVER_BUCK_ONE_RESERVED    3'h7
`define RVER_ENABLE_STATUS_RESET  8'h00
`define RVER_SEQ_GAP_NS           1000
`define RVER_CLK_PERIOD_NS        10
`define RVER_SEQ_GAP_CYCLES       (`RVER_SEQ_GAP_NS / `RVER_CLK_PERIOD_NS)
`endif

// file: src/rver_sync2.v
// Purpose: Two-flop synchroniser for one asynchronous level
// Assumes: Destination clock sys_clk, async active-low reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rver_sync2 (
  input  wire sys_clk,
  input  wire rst_b,
  input  wire async_in,
  output reg  sync_out
);
  reg meta_reg;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: src/rver_regs.v
// Purpose: Voltage select, enable and power-ok register bank of the PMU
// Assumes: Single-cycle byte register port from the serial slave, sys_clk
// Notes:   Fuse values are caught on the first clock after reset release
//
// Overview of operation
// - Buck one code sits in bits 2:0; bits 7:3 reserved.
// - Buck one codes 000..110 map to voltages; 111 reserved, default 101.
// - Buck two code in upper nibble; 0000..1000 all 1.1 V, default 1001.
// - Linear code in lower nibble; 0000 is 1.8 V default, +0.1 V each.
// - All voltage fields preload from fuses at power-up, then host read/write.
// - Bit 7 one switches buck one on; resets to zero.
// - Bit 6 one switches buck two on; resets to zero.
// - Bit 5 one switches linear regulator on; resets to zero.
// - With enable pin high, individual bits bypass the sequencer ordering.
// - Enable-all starts all in sequence, only while individual bits are zero.
// - Power-ok status in bits 3,2,1, read only, resets to zero.
// - Follow bit one drives release pin from power-ok signals.
// - Follow bit zero holds release pin low unless enable pin high.
// - Enable pin high makes release pin follow power-ok regardless of bit.
// - While thermal trip latched, writes to enable bits 7:4 are ignored.
// - Power-ok true once output reaches 80 percent of target.
// - Sequence order is buck one, linear, then buck two.
`timescale 1ns/1ps
`default_nettype none
`include "rver_consts.vh"
module rver_regs (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [2:0] fuse_buck_one_code,
  input  wire [3:0] fuse_buck_two_code,
  input  wire [3:0] fuse_linear_code,
  input  wire       enable_pin,
  input  wire       thermal_trip_latched,
  input  wire       buck_one_power_ok,
  input  wire       buck_two_power_ok,
  input  wire       linear_reg_power_ok,
  output reg  [2:0] buck_one_voltage_code,
  output reg  [3:0] buck_two_voltage_code,
  output reg  [3:0] linear_reg_voltage_code,
  output reg        buck_one_run,
  output reg        buck_two_run,
  output reg        linear_reg_run,
  output reg        shutdown_release_pin
);
  localparam [1:0] SEQ_IDLE = 2'd0;
  localparam [1:0] SEQ_ONE  = 2'd1;
  localparam [1:0] SEQ_LIN  = 2'd2;
  localparam [1:0] SEQ_TWO  = 2'd3;
  // Gap count is held 32 bits wide, then cut to the 16-bit counter on purpose
  localparam [31:0] GAP_WIDE = `RVER_SEQ_GAP_CYCLES;
  localparam [15:0] GAP = GAP_WIDE[15:0];

  wire en_s;
  wire tsd_s;
  wire ok1_s;
  wire ok2_s;
  wire okl_s;
  rver_sync2 u_en  (.sys_clk(sys_clk), .rst_b(rst_b),
                    .async_in(enable_pin), .sync_out(en_s));
  rver_sync2 u_tsd (.sys_clk(sys_clk), .rst_b(rst_b),
                    .async_in(thermal_trip_latched), .sync_out(tsd_s));
  rver_sync2 u_ok1 (.sys_clk(sys_clk), .rst_b(rst_b),
                    .async_in(buck_one_power_ok), .sync_out(ok1_s));
  rver_sync2 u_ok2 (.sys_clk(sys_clk), .rst_b(rst_b),
                    .async_in(buck_two_power_ok), .sync_out(ok2_s));
  rver_sync2 u_okl (.sys_clk(sys_clk), .rst_b(rst_b),
                    .async_in(linear_reg_power_ok), .sync_out(okl_s));

  reg        loaded_reg;
  reg        buck_one_on;
  reg        buck_two_on;
  reg        linear_reg_on;
  reg        enable_all;
  reg        release_pin_follow_power_ok;
  reg [1:0]  seq_reg;
  reg [1:0]  seq_next;
  reg [15:0] gap_reg;
  reg [15:0] gap_next;
  reg        en_d_reg;
  wire       any_ind = buck_one_on | buck_two_on | linear_reg_on;
  wire       en_rise = en_s & ~en_d_reg;

  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = (a == target);
    end
  endfunction

  // Voltage fields: fuse preload once after reset, then host writes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      loaded_reg              <= 1'b0;
      buck_one_voltage_code   <= 3'h0;
      buck_two_voltage_code   <= 4'h0;
      linear_reg_voltage_code <= 4'h0;
    end else if (!loaded_reg) begin
      loaded_reg              <= 1'b1;
      buck_one_voltage_code   <= fuse_buck_one_code;
      buck_two_voltage_code   <= fuse_buck_two_code;
      linear_reg_voltage_code <= fuse_linear_code;
    end else if (reg_wr) begin
      if (wr_hit(reg_addr, `RVER_ADDR_BUCK_ONE_VSEL))
        buck_one_voltage_code <= reg_wdata[2:0];
      if (wr_hit(reg_addr, `RVER_ADDR_BUCK_TWO_LIN)) begin
        buck_two_voltage_code   <= reg_wdata[7:4];
        linear_reg_voltage_code <= reg_wdata[3:0];
      end
    end
  end

  // Enable bits; a latched thermal trip blocks writes to bits 7:4, bit 0 is still written
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buck_one_on                 <= 1'b0;
      buck_two_on                 <= 1'b0;
      linear_reg_on               <= 1'b0;
      enable_all                  <= 1'b0;
      release_pin_follow_power_ok <= 1'b0;
    end else if (reg_wr && wr_hit(reg_addr, `RVER_ADDR_ENABLE_STATUS)) begin
      release_pin_follow_power_ok <= reg_wdata[`RVER_BIT_RELEASE_FOLLOW];
      if (!tsd_s) begin
        buck_one_on   <= reg_wdata[`RVER_BIT_BUCK_ONE_ON];
        buck_two_on   <= reg_wdata[`RVER_BIT_BUCK_TWO_ON];
        linear_reg_on <= reg_wdata[`RVER_BIT_LINEAR_ON];
        enable_all    <= reg_wdata[`RVER_BIT_ENABLE_ALL];
      end
    end
  end

  // Sequencer: buck one, linear, buck two, each after previous power-ok
  always @* begin
    seq_next = seq_reg;
    gap_next = gap_reg;
    case (seq_reg)
      SEQ_IDLE: begin
        gap_next = 16'h0000;
        if ((enable_all && !any_ind && !tsd_s) || en_rise)
          seq_next = SEQ_ONE;
      end
      SEQ_ONE: begin
        if (ok1_s) begin
          if (gap_reg == GAP - 16'h0001) begin
            seq_next = SEQ_LIN;
            gap_next = 16'h0000;
          end else
            gap_next = gap_reg + 16'h0001;
        end
      end
      SEQ_LIN: begin
        if (okl_s) begin
          if (gap_reg == GAP - 16'h0001)
            seq_next = SEQ_TWO;
          else
            gap_next = gap_reg + 16'h0001;
        end
      end
      SEQ_TWO: begin
        gap_next = 16'h0000;
      end
      default: begin
        seq_next = SEQ_IDLE;
      end
    endcase
    // Sequence drops on a trip, with enable-all and enable pin both low, or with an individual bit set while the pin is low
    if (tsd_s || (!enable_all && !en_s) || (any_ind && !en_s))
      seq_next = SEQ_IDLE;
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_reg  <= SEQ_IDLE;
      gap_reg  <= 16'h0000;
      en_d_reg <= 1'b0;
    end else begin
      seq_reg  <= seq_next;
      gap_reg  <= gap_next;
      en_d_reg <= en_s;
    end
  end

  // Run outputs; individual bits act directly and never wait on the order
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buck_one_run   <= 1'b0;
      buck_two_run   <= 1'b0;
      linear_reg_run <= 1'b0;
    end else begin
      buck_one_run   <= !tsd_s && (buck_one_on || seq_reg != SEQ_IDLE);
      linear_reg_run <= !tsd_s && (linear_reg_on ||
                        seq_reg == SEQ_LIN || seq_reg == SEQ_TWO);
      buck_two_run   <= !tsd_s && (buck_two_on || seq_reg == SEQ_TWO);
    end
  end

  // Release pin: all power-ok when following or enable pin high, else held low
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      shutdown_release_pin <= 1'b0;
    else if (release_pin_follow_power_ok || en_s)
      shutdown_release_pin <= ok1_s & ok2_s & okl_s;
    else
      shutdown_release_pin <= 1'b0;
  end

  // Read data, reserved and unmapped bits read zero
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `RVER_ADDR_BUCK_ONE_VSEL:
          reg_rdata <= {5'h00, buck_one_voltage_code};
        `RVER_ADDR_BUCK_TWO_LIN:
          reg_rdata <= {buck_two_voltage_code, linear_reg_voltage_code};
        `RVER_ADDR_ENABLE_STATUS:
          reg_rdata <= {buck_one_on, buck_two_on, linear_reg_on, enable_all,
                        ok1_s, ok2_s, okl_s,
                        release_pin_follow_power_ok};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: test/rver_regs_chk.sv
// Purpose: Port assertions for rver_regs
// Assumes: One clock, async low reset
// Notes:   Bound below the module
`timescale 1ns/1ps
`default_nettype none
module rver_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       thermal_trip_latched,
  input wire logic       buck_one_power_ok,
  input wire logic [2:0] buck_one_voltage_code,
  input wire logic       buck_one_run,
  input wire logic       shutdown_release_pin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Flag low three cycles so its synchroniser is clear
  sequence s_on_write;
    (!thermal_trip_latched)[*3] ##0
      reg_wr && reg_addr == 8'h03 && reg_wdata[7];
  endsequence
  a_on_write: assert property (s_on_write |=> ##1 buck_one_run)
    else $error("buck one not on");
  a_code_write: assert property (reg_wr && reg_addr == 8'h01 |=>
    {5'h00, buck_one_voltage_code} == ($past(reg_wdata) & 8'h07))
    else $error("code not written");
  a_code_read: assert property (reg_rd && reg_addr == 8'h01 |=>
    reg_rdata == {5'h00, buck_one_voltage_code})
    else $error("code read wrong");
  a_unmapped_zero: assert property (reg_rd &&
    (reg_addr == 8'h00 || reg_addr > 8'h03) |=> reg_rdata == 8'h00)
    else $error("unmapped not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_read_quiet: assert property (reg_rd && !reg_wr |=>
    $stable(buck_one_voltage_code))
    else $error("read changed code");
  a_pin_needs_ok: assert property (
    (!buck_one_power_ok)[*4] |-> !shutdown_release_pin)
    else $error("pin high without ok");
  a_thermal_lock: assert property (
    thermal_trip_latched[*6] |-> !$rose(buck_one_run))
    else $error("start during trip");
endmodule
bind rver_regs rver_chk u_rver_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .thermal_trip_latched(thermal_trip_latched),
  .buck_one_power_ok(buck_one_power_ok),
  .buck_one_voltage_code(buck_one_voltage_code),
  .buck_one_run(buck_one_run), .shutdown_release_pin(shutdown_release_pin));
`default_nettype wire

// file: test/rver_load.sv
// Purpose: Regulator outputs seen by the bank
// Assumes: Power ok on the RISE+1th clock edge that sees run high
// Notes:   Drops on the first clock edge that sees run low
`timescale 1ns/1ps
`default_nettype none
module rver_load #(
  parameter int RISE = 20
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] run,
  output var  logic [2:0] power_ok
);
  int cnt [3];
  always @(posedge sys_clk or negedge rst_b) begin
    for (int k = 0; k < 3; k++) begin
      if (!rst_b || !run[k]) begin
        cnt[k] <= 0;
        power_ok[k] <= 1'b0;
      end else if (cnt[k] < RISE) begin
        cnt[k] <= cnt[k] + 1;
      end else begin
        power_ok[k] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/rver_regs_tb.sv
// Purpose: Self-checking bench for rver_regs
// Assumes: rver_load stands in for the regulators
// Notes:   Read data checked from a queue
`timescale 1ns/1ps
`default_nettype none
module rver_regs_tb;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        en = 1'b0;
  logic        hot = 1'b0;
  logic        rd_seen = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [10:0] fuse = 11'h000;
  logic [7:0]  exp_q [$];
  wire  [7:0]  reg_rdata;
  wire  [2:0]  run;
  wire  [2:0]  power_ok_signal;
  wire         pin;
  wire  [10:0] code;
  int          err_count = 0;
  int          checks = 0;
  always #5 sys_clk = ~sys_clk;
  rver_regs u_rver_regs (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .fuse_buck_one_code(fuse[10:8]),
    .fuse_buck_two_code(fuse[7:4]), .fuse_linear_code(fuse[3:0]),
    .enable_pin(en), .thermal_trip_latched(hot),
    .buck_one_power_ok(power_ok_signal[0]), .linear_reg_power_ok(power_ok_signal[1]),
    .buck_two_power_ok(power_ok_signal[2]), .buck_one_voltage_code(code[10:8]),
    .buck_two_voltage_code(code[7:4]), .linear_reg_voltage_code(code[3:0]),
    .buck_one_run(run[0]), .linear_reg_run(run[1]), .buck_two_run(run[2]),
    .shutdown_release_pin(pin));
  rver_load u_rver_load (.sys_clk(sys_clk), .rst_b(rst_b), .run(run),
    .power_ok(power_ok_signal));
  task automatic complete_run();
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tally(string nm, logic [10:0] e, logic [10:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_rdata(logic [7:0] e, logic [7:0] g);
    tally("rdata", {3'h0, e}, {3'h0, g});
  endtask
  task automatic cmp_level(string nm, logic [7:0] e, logic [7:0] g);
    tally(nm, {3'h0, e}, {3'h0, g});
  endtask
  task automatic cmp_code(logic [10:0] e, logic [10:0] g);
    tally("code", e, g);
  endtask
  // A read notes its expected byte; the monitor below compares it
  task automatic acc(bit w, logic [7:0] a, logic [7:0] d);
    if (!w)
      exp_q.push_back(d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Idle edge so the next call never drives a strobe twice in one step
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen)
      cmp_rdata(exp_q.pop_front(), reg_rdata);
  end
  function automatic logic [7:0] lvl(bit p);
    return p ? {7'h00, pin} : {5'h00, run};
  endfunction
  // Bounded wait for a level, checked mid-cycle; any miss ends the run
  task automatic see(bit p, logic [7:0] e, int n);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (lvl(p) !== e && k < n) begin
      @(negedge sys_clk);
      k++;
    end
    cmp_level(p ? "pin" : "run", e, lvl(p));
    if (err_count > 0)
      complete_run();
    @(posedge sys_clk);
  endtask
  initial begin
    logic [7:0] d;
    d = 8'($urandom(32'h71de));
    fuse <= 11'($urandom());
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    acc(0, 8'h01, {5'h00, fuse[10:8]});
    acc(0, 8'h02, fuse[7:0]);
    acc(0, 8'h03, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom());
      acc(1, 8'h01, {d[7:3], 3'(i)});
      acc(0, 8'h01, {5'h00, 3'(i)});
      acc(1, 8'h02, d);
      cmp_code({3'(i), d}, code);
      acc(0, 8'h02, d);
    end
    acc(0, 8'h0f, 8'h00);
    acc(1, 8'h03, 8'h80);
    see(0, 8'h01, 2);
    repeat (30) @(posedge sys_clk);
    see(1, 8'h00, 0);
    acc(0, 8'h03, 8'h88);
    acc(1, 8'h03, 8'he1);
    see(0, 8'h07, 2);
    see(1, 8'h01, 40);
    acc(0, 8'h03, 8'hef);
    acc(1, 8'h03, 8'h00);
    see(0, 8'h00, 2);
    repeat (10) @(posedge sys_clk);
    acc(1, 8'h03, 8'h10);
    see(0, 8'h01, 20);
    see(0, 8'h03, 400);
    see(0, 8'h07, 400);
    acc(1, 8'h03, 8'h00);
    hot <= 1'b1;
    see(0, 8'h00, 10);
    repeat (5) @(posedge sys_clk);
    acc(1, 8'h03, 8'h81);
    repeat (5) @(posedge sys_clk);
    see(0, 8'h00, 0);
    acc(0, 8'h03, 8'h01);
    hot <= 1'b0;
    acc(1, 8'h03, 8'h00);
    en <= 1'b1;
    see(0, 8'h07, 600);
    see(1, 8'h01, 40);
    complete_run();
  end
endmodule
`default_nettype wire
